// *** inc/color_interp_regs.svh ***
// Register indices, field positions, reset values and sizes of the colour interpolator
`ifndef COLOR_INTERP_REGS_SVH
`define COLOR_INTERP_REGS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define CI_IDX_RED_START        4'h0
`define CI_IDX_RED_STEP_X       4'h1
`define CI_IDX_RED_STEP_EDGE    4'h2
`define CI_IDX_GREEN_START      4'h3
`define CI_IDX_GREEN_STEP_X     4'h4
`define CI_IDX_GREEN_STEP_EDGE  4'h5
`define CI_IDX_BLUE_START       4'h6
`define CI_IDX_BLUE_STEP_X      4'h7
`define CI_IDX_BLUE_STEP_EDGE   4'h8
`define CI_IDX_ALPHA_START      4'h9
`define CI_IDX_ALPHA_STEP_X     4'ha
`define CI_IDX_ALPHA_STEP_EDGE  4'hb
`define CI_IDX_FLAT_FILL_COLOR  4'hc
`define CI_IDX_SHADER_CONTROL   4'hd
`define CI_IDX_STATUS           4'he

// ****************************************************************
// Setup layout: three words per component
// ****************************************************************
`define CI_SETUP_WORDS          12
`define CI_SETUP_START          0
`define CI_SETUP_STEP_X         1
`define CI_SETUP_STEP_EDGE      2

// ****************************************************************
// Shader control fields
// ****************************************************************
`define CI_CTRL_UNIT_ON         0
`define CI_CTRL_SMOOTH          1
`define CI_CTRL_PALETTE         2

// ****************************************************************
// Draw command payload fields
// ****************************************************************
`define CI_DRAW_SUBPIX_EN       8
`define CI_SUBPIX_FRAC_BITS     8

// ****************************************************************
// Reset values and sizes
// ****************************************************************
`define CI_CTRL_RESET           3'h0
`define CI_FLAT_RESET           32'h0000_0000
`define CI_SETUP_RESET          24'h00_0000
`define CI_FIFO_DEPTH           8
`define CI_FIFO_COUNT_BITS      4

`endif

// *** inc/color_pkg.sv ***
// Types and arithmetic helpers shared by both ends of the colour link
package color_pkg;

  // ****************************************************************
  // Words on the link
  // ****************************************************************
  typedef logic signed [23:0] fixed_9_15_type;

  typedef struct packed {
    logic        is_draw;
    logic        new_span;
    logic [31:0] payload;
  } frag_word_type;

  // ****************************************************************
  // Device end state
  // ****************************************************************
  typedef struct packed {
    logic [11:0][23:0] setup;
    logic [31:0]       flat;
    logic [2:0]        mode;
    logic [3:0][23:0]  edge_acc;
    logic [3:0][23:0]  span_acc;
    logic              first_span;
    logic              out_valid;
    logic [31:0]       out_color;
    logic              rvalid;
    logic [31:0]       rdata;
  } interp_state_type;

  // ****************************************************************
  // Source end state
  // ****************************************************************
  typedef struct packed {
    logic          out_valid;
    frag_word_type out_data;
    logic          reg_wr;
    logic          reg_rd;
    logic [3:0]    reg_addr;
    logic [31:0]   reg_wdata;
    logic          cfg_rvalid;
    logic [31:0]   cfg_rdata;
  } source_state_type;

  // Saturate instead of wrapping on overflow
  function automatic logic [23:0] sat_add(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] sum;
    sum = {a[23], a} + {b[23], b};
    if (sum[24] != sum[23]) begin
      sat_add = sum[24] ? 24'h80_0000 : 24'h7f_ffff;
    end else begin
      sat_add = sum[23:0];
    end
  endfunction

  // Negative gives zero; nine signed integer bits cannot exceed 255
  function automatic logic [7:0] to_byte(input logic [23:0] v);
    to_byte = v[23] ? 8'h00 : v[22:15];
  endfunction

endpackage

// *** inc/color_link_if.sv ***
// Link between the fragment source and the colour interpolator
`timescale 1ns/1ps
interface color_link_if;
  import color_pkg::*;

  logic          reg_wr;
  logic          reg_rd;
  logic [3:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic [31:0]   reg_rdata;
  logic          reg_rvalid;
  logic          frag_valid;
  logic          frag_ready;
  frag_word_type frag_data;

  modport device (
    input  reg_wr,
    input  reg_rd,
    input  reg_addr,
    input  reg_wdata,
    output reg_rdata,
    output reg_rvalid,
    input  frag_valid,
    output frag_ready,
    input  frag_data
  );

  modport source (
    output reg_wr,
    output reg_rd,
    output reg_addr,
    output reg_wdata,
    input  reg_rdata,
    input  reg_rvalid,
    output frag_valid,
    input  frag_ready,
    output frag_data
  );
endinterface // color_link_if

// *** src/color_interp.sv ***
// Colour interpolator device end with its input fragment FIFO
//
// Behaviour
// [RULE1] Colour held as four packed 8-bit components
// [RULE2] Software left-justifies narrow components, zero fill
// [RULE3] Palette index sits in low red byte
// [RULE4] Smooth mode: start plus accumulated increments
// [RULE5] Clamp components, never wrap
// [RULE6] Step dominant edge, then step across span
// [RULE7] Each component has edge and span increments
// [RULE8] Lines use only start and edge increment
// [RULE9] Values are signed 9.15 fixed point
// [RULE10] Every draw reloads from stored start values
// [RULE11] Subpixel correction also applied to colour
// [RULE12] Flat mode: every fragment gets constant colour
// [RULE13] Start, span and edge registers per component
// [RULE14] Software enables unit only for rendering
// [RULE15] Control holds unit enable and shading select
// [RULE16] Disabled unit passes colour through unchanged
`timescale 1ns/1ps
`include "color_interp_regs.svh"

// ****************************************************************
// Fragment FIFO
// ****************************************************************
module frag_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_type;

  fifo_state_type s_q;
  fifo_state_type s_d;
  logic           push;
  logic           pop;

  assign in_ready  = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rd];
  assign count     = s_q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = in_data;
      s_d.wr          = (s_q.wr == AW'(DEPTH-1)) ? '0 : s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = (s_q.rd == AW'(DEPTH-1)) ? '0 : s_q.rd + 1'b1;
    end
    // Both in one cycle leaves the count unchanged
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // frag_fifo

// ****************************************************************
// Interpolator
// ****************************************************************
module color_interp
  import color_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  color_link_if.device      link,
  output logic              pix_valid,
  input  wire logic         pix_ready,
  output logic [31:0]       pix_color
);
  interp_state_type   s_q;
  interp_state_type   s_d;
  logic               fifo_valid;
  logic               fifo_pop;
  logic [33:0]        fifo_raw;
  frag_word_type      entry;
  logic [`CI_FIFO_COUNT_BITS-1:0] fifo_count;
  logic               unit_on;
  logic               smooth;
  logic               palette;

  // Fragments are buffered so the rasteriser is only stalled when eight are pending
  frag_fifo #(
    .WIDTH (34),
    .DEPTH (`CI_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_valid  (link.frag_valid),
    .in_ready  (link.frag_ready),
    .in_data   (link.frag_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_raw),
    .count     (fifo_count)
  );

  assign entry   = frag_word_type'(fifo_raw);
  assign unit_on = s_q.mode[`CI_CTRL_UNIT_ON];  // see [RULE15]
  assign smooth  = s_q.mode[`CI_CTRL_SMOOTH];   // see [RULE15]
  assign palette = s_q.mode[`CI_CTRL_PALETTE];

  // Draws never produce a pixel, so they drain even while the output is stalled
  assign fifo_pop = fifo_valid && (entry.is_draw || !s_q.out_valid || pix_ready);

  assign pix_valid       = s_q.out_valid;
  assign pix_color       = s_q.out_color;
  assign link.reg_rdata  = s_q.rdata;
  assign link.reg_rvalid = s_q.rvalid;

  always_comb begin
    logic [23:0]        start;
    logic [23:0]        step_x;
    logic [23:0]        step_edge;
    logic [23:0]        edge_v;
    logic signed [32:0] prod;
    logic [3:0][7:0]    comp;
    s_d       = s_q;
    start     = '0;
    step_x    = '0;
    step_edge = '0;
    edge_v    = '0;
    prod      = '0;
    comp      = '0;

    // ****************************************************************
    // Register writes and reads
    // ****************************************************************
    s_d.rvalid = link.reg_rd;
    if (link.reg_wr) begin
      if (link.reg_addr < 4'(`CI_SETUP_WORDS)) begin
        s_d.setup[link.reg_addr] = link.reg_wdata[23:0];  // see [RULE9] [RULE13]
      end else if (link.reg_addr == `CI_IDX_FLAT_FILL_COLOR) begin
        s_d.flat = link.reg_wdata;  // see [RULE12]
      end else if (link.reg_addr == `CI_IDX_SHADER_CONTROL) begin
        s_d.mode = link.reg_wdata[2:0];
      end
    end
    if (link.reg_rd) begin
      if (link.reg_addr < 4'(`CI_SETUP_WORDS)) begin
        s_d.rdata = {8'h00, s_q.setup[link.reg_addr]};
      end else if (link.reg_addr == `CI_IDX_FLAT_FILL_COLOR) begin
        s_d.rdata = s_q.flat;
      end else if (link.reg_addr == `CI_IDX_SHADER_CONTROL) begin
        s_d.rdata = {29'h0000_0000, s_q.mode};
      end else if (link.reg_addr == `CI_IDX_STATUS) begin
        s_d.rdata = {26'h000_0000, s_q.first_span, fifo_count, s_q.out_valid};
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end

    // ****************************************************************
    // Fragment processing
    // ****************************************************************
    if (s_q.out_valid && pix_ready) begin
      s_d.out_valid = 1'b0;
    end
    if (fifo_pop) begin
      for (int c = 0; c < 4; c++) begin
        start     = s_q.setup[c*3 + `CI_SETUP_START];      // see [RULE7]
        step_x    = s_q.setup[c*3 + `CI_SETUP_STEP_X];     // see [RULE7]
        step_edge = s_q.setup[c*3 + `CI_SETUP_STEP_EDGE];  // see [RULE7]
        if (entry.is_draw) begin
          // Reload from the stored start so repeated draws give identical colours
          if (entry.payload[`CI_DRAW_SUBPIX_EN]) begin
            prod  = $signed(step_edge) * $signed({1'b0, entry.payload[`CI_SUBPIX_FRAC_BITS-1:0]});
            start = sat_add(start, prod[31:8]);  // see [RULE11]
          end
          s_d.edge_acc[c] = start;  // see [RULE10]
          s_d.span_acc[c] = start;  // see [RULE10]
        end else if (entry.new_span) begin
          // A line sends every fragment as a new span, so only the edge step is used
          edge_v          = s_q.first_span ? s_q.edge_acc[c] : sat_add(s_q.edge_acc[c], step_edge);  // see [RULE6] [RULE8]
          s_d.edge_acc[c] = edge_v;
          s_d.span_acc[c] = edge_v;
        end else begin
          s_d.span_acc[c] = sat_add(s_q.span_acc[c], step_x);  // see [RULE4] [RULE6]
        end
        comp[c] = to_byte(s_d.span_acc[c]);  // see [RULE5]
      end
      if (entry.is_draw) begin
        s_d.first_span = 1'b1;
      end else begin
        s_d.first_span = 1'b0;
        s_d.out_valid  = 1'b1;
        if (!unit_on) begin
          s_d.out_color = entry.payload;  // see [RULE16]
        end else if (!smooth) begin
          s_d.out_color = s_q.flat;  // see [RULE12]
        end else if (palette) begin
          s_d.out_color = {24'h00_0000, comp[0]};  // see [RULE3]
        end else begin
          s_d.out_color = {comp[3], comp[2], comp[1], comp[0]};  // see [RULE1]
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q      <= '0;
      s_q.mode <= `CI_CTRL_RESET;
      s_q.flat <= `CI_FLAT_RESET;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // color_interp

// *** src/fragment_source.sv ***
// Fragment source end: forwards setup accesses, draws and fragments onto the link
`timescale 1ns/1ps
`include "color_interp_regs.svh"

module fragment_source
  import color_pkg::*;
(
  input  wire logic         clk_sys,
  input  wire logic         reset,
  color_link_if.source      link,
  input  wire logic         cfg_wr,
  input  wire logic         cfg_rd,
  input  wire logic [3:0]   cfg_addr,
  input  wire logic [31:0]  cfg_wdata,
  output logic              cfg_rvalid,
  output logic [31:0]       cfg_rdata,
  input  wire logic         draw_req,
  input  wire logic         draw_subpix,
  input  wire logic [7:0]   draw_frac,
  output logic              draw_ready,
  input  wire logic         frag_in_valid,
  input  wire logic         frag_in_new_span,
  input  wire logic         frag_in_line,
  input  wire logic [31:0]  frag_in_color,
  input  wire logic [3:0]   frag_in_bits,
  output logic              frag_in_ready
);
  source_state_type s_q;
  source_state_type s_d;
  logic             can_send;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  assign can_send      = !s_q.out_valid || link.frag_ready;
  assign draw_ready    = can_send;
  assign frag_in_ready = can_send && !draw_req;

  assign link.frag_valid = s_q.out_valid;
  assign link.frag_data  = s_q.out_data;
  assign link.reg_wr     = s_q.reg_wr;
  assign link.reg_rd     = s_q.reg_rd;
  assign link.reg_addr   = s_q.reg_addr;
  assign link.reg_wdata  = s_q.reg_wdata;
  assign cfg_rvalid      = s_q.cfg_rvalid;
  assign cfg_rdata       = s_q.cfg_rdata;

  always_comb begin
    logic [7:0] keep;
    s_d  = s_q;
    keep = 8'hff;

    // Setup accesses; software decides unit_on per operation type
    s_d.reg_wr     = cfg_wr;  // see [RULE14]
    s_d.reg_rd     = cfg_rd;
    s_d.reg_addr   = cfg_addr;
    s_d.reg_wdata  = cfg_wdata;
    s_d.cfg_rvalid = link.reg_rvalid;
    if (link.reg_rvalid) begin
      s_d.cfg_rdata = link.reg_rdata;
    end

    // Narrow components are already left-justified; clear the spare low bits
    if (frag_in_bits != 4'h0 && frag_in_bits < 4'h8) begin
      keep = 8'hff << (4'h8 - frag_in_bits);
    end

    if (link.frag_ready) begin
      s_d.out_valid = 1'b0;
    end
    if (draw_req && can_send) begin
      s_d.out_valid                               = 1'b1;
      s_d.out_data                                = '0;
      s_d.out_data.is_draw                        = 1'b1;
      s_d.out_data.payload[`CI_DRAW_SUBPIX_EN]    = draw_subpix;
      s_d.out_data.payload[`CI_SUBPIX_FRAC_BITS-1:0] = draw_frac;
    end else if (frag_in_valid && frag_in_ready) begin
      s_d.out_valid         = 1'b1;
      s_d.out_data.is_draw  = 1'b0;
      s_d.out_data.new_span = frag_in_new_span || frag_in_line;  // see [RULE8]
      s_d.out_data.payload  = frag_in_color & {4{keep}};  // see [RULE2] [RULE3]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // fragment_source

// *** testbench/color_link_sva.sv ***
// Protocol assertions on the link between fragment source and interpolator
`timescale 1ns/1ps
module color_link_sva
  import color_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          reset,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [3:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic [31:0]   reg_rdata,
  input wire logic          reg_rvalid,
  input wire logic          frag_valid,
  input wire logic          frag_ready,
  input wire frag_word_type frag_data
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ********
  // Properties
  // ********
  // Write then read of the same index on consecutive cycles
  sequence s_wr_rd;
    reg_wr ##1 (reg_rd && reg_addr == $past(reg_addr));
  endsequence

  property p_setup;
    s_wr_rd ##0 (reg_addr < 4'hc) |=> reg_rvalid && reg_rdata == ($past(reg_wdata, 2) & 32'h00ff_ffff);
  endproperty
  property p_flat;
    s_wr_rd ##0 (reg_addr == 4'hc) |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
  endproperty
  property p_ctrl;
    s_wr_rd ##0 (reg_addr == 4'hd) |=> reg_rdata == ($past(reg_wdata, 2) & 32'h0000_0007);
  endproperty
  property p_rvalid;
    reg_rd |=> reg_rvalid;
  endproperty
  property p_quiet;
    !reg_rd |=> !reg_rvalid;
  endproperty
  property p_unmapped;
    reg_rd && reg_addr == 4'hf |=> reg_rdata == 32'h0;
  endproperty
  // Stalled words must not change under the FIFO
  property p_hold;
    frag_valid && !frag_ready |=> frag_valid && $stable(frag_data);
  endproperty
  property p_reset;
    $fell(reset) |-> !frag_valid && !reg_rvalid && !reg_wr && !reg_rd;
  endproperty

  a_setup: assert property (p_setup) else $error("setup readback wrong");
  a_flat: assert property (p_flat) else $error("flat colour readback wrong");
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  a_quiet: assert property (p_quiet) else $error("answer without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hold: assert property (p_hold) else $error("stalled word changed");
  a_reset: assert property (p_reset) else $error("link busy after reset");
endmodule // color_link_sva

// *** testbench/tb_top.sv ***
// Self-checking bench joining fragment source and colour interpolator
`timescale 1ns/1ps
module tb_top;
  import color_pkg::*;
  logic        clk_sys, reset, cfg_wr, cfg_rd, cfg_rvalid, draw_req, draw_subpix, draw_ready;
  logic        frag_in_valid, frag_in_new_span, frag_in_line, frag_in_ready, pix_valid, pix_ready;
  logic [3:0]  cfg_addr, frag_in_bits;
  logic [7:0]  draw_frac;
  logic [31:0] cfg_wdata, cfg_rdata, frag_in_color, pix_color, rd_q;
  logic [23:0] tbl [12];
  int          bad_count, checks;

  color_link_if link_bus ();
  fragment_source i_fragment_source (.clk_sys, .reset, .link(link_bus), .cfg_wr, .cfg_rd, .cfg_addr,
    .cfg_wdata, .cfg_rvalid, .cfg_rdata, .draw_req, .draw_subpix, .draw_frac, .draw_ready,
    .frag_in_valid, .frag_in_new_span, .frag_in_line, .frag_in_color, .frag_in_bits, .frag_in_ready);
  color_interp i_color_interp (.clk_sys, .reset, .link(link_bus), .pix_valid, .pix_ready, .pix_color);
  color_link_sva i_color_link_sva (.clk_sys, .reset, .reg_wr(link_bus.reg_wr), .reg_rd(link_bus.reg_rd),
    .reg_addr(link_bus.reg_addr), .reg_wdata(link_bus.reg_wdata), .reg_rdata(link_bus.reg_rdata),
    .reg_rvalid(link_bus.reg_rvalid), .frag_valid(link_bus.frag_valid),
    .frag_ready(link_bus.frag_ready), .frag_data(link_bus.frag_data));

  // ********
  // Shared tasks
  // ********
  task automatic test_done;
    $display("Counts: %0d mismatches in %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    test_done();
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Write and read back to back when both asked
  task automatic cfg(input bit w, input bit r, input logic [3:0] a, input logic [31:0] d);
    int i;
    if (w) begin
      @(posedge clk_sys);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
    end
    if (r) begin
      @(posedge clk_sys);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b1;
      cfg_addr <= a;
    end
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    if (r) begin
      for (i = 0; i < 10 && cfg_rvalid !== 1'b1; i++) begin
        @(negedge clk_sys);
      end
      if (i == 10) timeout();
      rd_q = cfg_rdata;
    end
  endtask

  // Draws reuse ns as subpixel enable and col[7:0] as fraction
  task automatic push(input bit drw, input bit ns, input bit ln, input logic [31:0] col,
                      input logic [3:0] bits, input int lim, output bit ok);
    int i;
    @(posedge clk_sys);
    draw_req <= drw;
    frag_in_valid <= !drw;
    frag_in_new_span <= ns;
    frag_in_line <= ln;
    frag_in_color <= col;
    frag_in_bits <= bits;
    draw_subpix <= ns;
    draw_frac <= col[7:0];
    ok = 1'b0;
    for (i = 0; i < lim && !ok; i++) begin
      @(negedge clk_sys);
      ok = drw ? draw_ready === 1'b1 : frag_in_ready === 1'b1;
      @(posedge clk_sys);
    end
    draw_req <= 1'b0;
    frag_in_valid <= 1'b0;
  endtask

  task automatic send(input bit drw, input bit ns, input bit ln, input logic [31:0] col, input logic [3:0] bits);
    bit ok;
    push(drw, ns, ln, col, bits, 50, ok);
    if (!ok) timeout();
  endtask

  task automatic get_pix(input logic [31:0] exp);
    int i;
    for (i = 0; i < 60; i++) begin
      @(negedge clk_sys);
      if (pix_valid === 1'b1) break;
    end
    if (i == 60) timeout();
    check(pix_color, exp);
    @(posedge clk_sys);
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    int k;
    // Index 14 is the idle status word, all zero after reset
    for (k = 0; k < 15; k++) begin
      cfg(0, 1, 4'(k), 32'h0);
      check(rd_q, 32'h0);
    end
    for (k = 0; k < 12; k++) begin
      cfg(1, 1, 4'(k), 32'hff80_0001 + 32'(k));
      check(rd_q, 32'h0080_0001 + 32'(k));
    end
    cfg(1, 1, 4'hc, 32'ha5c3_5a3c);
    check(rd_q, 32'ha5c3_5a3c);
    cfg(1, 1, 4'hd, 32'hffff_ffff);
    check(rd_q, 32'h0000_0007);
    cfg(1, 1, 4'he, 32'hffff_ffff);
    check(rd_q, 32'h0);
    cfg(1, 1, 4'hf, 32'hffff_ffff);
    check(rd_q, 32'h0);
  endtask

  task automatic t_pass;
    cfg(1, 0, 4'hd, 32'h0);
    send(0, 1, 0, 32'h9abc_def1, 4'h0);
    get_pix(32'h9abc_def1);
    send(0, 0, 0, 32'hffff_ffff, 4'h4);
    get_pix(32'hf0f0_f0f0);
    send(0, 0, 0, 32'h7f80_ffff, 4'h1);
    get_pix(32'h0080_8080);
  endtask

  // Stall the pixel side until the link refuses, then drain in order
  task automatic t_fifo;
    int n;
    int k;
    bit ok;
    @(posedge clk_sys);
    pix_ready <= 1'b0;
    for (n = 0; n < 20; n++) begin
      push(0, 0, 0, 32'h0101_0101 * 32'(n + 1), 4'h0, 4, ok);
      if (!ok) break;
    end
    check({31'h0, link_bus.frag_ready}, 32'h0);
    check(n >= 8 ? 32'h1 : 32'h0, 32'h1);
    // Status while stalled: eight queued, one pixel waiting
    cfg(0, 1, 4'he, 32'h0);
    check(rd_q, 32'h0000_0011);
    @(posedge clk_sys);
    pix_ready <= 1'b1;
    for (k = 0; k < n; k++) begin
      get_pix(32'h0101_0101 * 32'(k + 1));
    end
  endtask

  task automatic t_flat;
    cfg(1, 0, 4'hc, 32'ha1b2_c3d4);
    cfg(1, 0, 4'hd, 32'h1);
    send(0, 1, 0, 32'h1234_5678, 4'h0);
    get_pix(32'ha1b2_c3d4);
    send(0, 0, 0, 32'hffff_ffff, 4'h0);
    get_pix(32'ha1b2_c3d4);
  endtask

  task automatic t_smooth;
    int k;
    for (k = 0; k < 12; k++) begin
      cfg(1, 0, 4'(k), {8'h0, tbl[k]});
    end
    cfg(1, 0, 4'hd, 32'h3);
    send(1, 0, 0, 32'h0, 4'h0);
    send(0, 1, 0, 32'h0, 4'h0);
    get_pix(32'h7f05_fa0a);
    send(0, 0, 0, 32'h0, 4'h0);
    get_pix(32'h7f00_ff0b);
    send(0, 1, 0, 32'h0, 4'h0);
    get_pix(32'h7f05_fa0c);
    send(1, 0, 0, 32'h0, 4'h0);
    send(0, 1, 0, 32'h0, 4'h0);
    get_pix(32'h7f05_fa0a);
    send(0, 0, 1, 32'h0, 4'h0);
    get_pix(32'h7f05_fa0c);
    send(1, 1, 0, 32'h80, 4'h0);
    send(0, 1, 0, 32'h0, 4'h0);
    get_pix(32'h7f05_fa0b);
    cfg(1, 0, 4'hd, 32'h7);
    send(1, 0, 0, 32'h0, 4'h0);
    send(0, 1, 0, 32'h0, 4'h0);
    get_pix(32'h0000_000a);
  endtask

  // ********
  // Clock, reset and sequence
  // ********
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  initial begin
    // Start 10, 250 with overflow, 5 with underflow, 127 held
    tbl = '{24'h05_0000, 24'h00_8000, 24'h01_0000, 24'h7d_0000, 24'h04_0000, 24'h0,
            24'h02_8000, 24'hfc_0000, 24'h0, 24'h3f_8000, 24'h0, 24'h0};
    {reset, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, draw_req, draw_subpix, draw_frac} = '0;
    {frag_in_valid, frag_in_new_span, frag_in_line, frag_in_color, frag_in_bits} = '0;
    reset = 1'b1;
    pix_ready = 1'b1;
    bad_count = 0;
    checks = 0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_pass();
    t_fifo();
    t_flat();
    t_smooth();
    test_done();
  end
endmodule // tb_top
